// [pmp_mac_model.sv]
module pmp_mac_model (
   input wire logic xfer_clk,
   input wire logic [3:0] rxd,
   input wire logic rx_dv,
   input wire logic rx_er,
   output logic [3:0] txd,
   output logic tx_en,
   output logic tx_er
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [5:0] tx_q[$];
   logic [5:0] rx_q[$];

   initial
   begin
      txd = 4'h0;
      tx_en = 1'b0;
      tx_er = 1'b0;
   end

   // Receive pins sampled mid-period, clear of the edge that launches them
   always @(negedge xfer_clk)
   begin
      if (rx_dv || rx_er)
      begin
         rx_q.push_back({rx_dv, rx_er, rxd});
      end
   end

   always @(posedge xfer_clk)
   begin
      #1;
      if (tx_q.size() > 0)
      begin
         {tx_en, tx_er, txd} = tx_q.pop_front();
      end
      else
      begin
         tx_en = 1'b0;
         tx_er = 1'b0;
         // Idle data keeps changing so a design that ignores the enable shows it
         txd = ~txd;
      end
   end
endmodule : pmp_mac_model

// [pmp_mem.sv]
module pmp_mem #(
   parameter int W = 7,
   parameter int AW = 3
) (
   input logic wclk,
   input logic we,
   input logic [AW-1:0] waddr,
   input logic [W-1:0] wdata,
   input logic rclk,
   input logic re,
   input logic [AW-1:0] raddr,
   output logic [W-1:0] rdata
);
   logic [W-1:0] mem [2**AW];

   always_ff @(posedge wclk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
   end

   // Registered read; the clock enable freezes it like all state except the pin synchronisers
   always_ff @(posedge rclk)
   begin
      if (re)
      begin
         rdata <= mem[raddr];
      end
   end
endmodule : pmp_mem

// [pmp_mii_rmii_port.sv]
module pmp_mii_rmii_port (
   input logic CORE_CLK,
   input logic NRST,
   input logic CE,
   input logic REF_CLOCK_INPUT_PIN,
   input logic RMII_MODE,
   input logic RMII_MASTER,
   input logic [2:0] FIFO_THRESH,
   input logic [3:0] TXD,
   input logic TX_EN,
   input logic TX_ER,
   output logic [3:0] RXD,
   output logic RX_DV,
   output logic RX_ER,
   output logic CRS_DV,
   output logic MII_TX_CLK,
   output logic MII_RX_CLK,
   input pmp_pkg::pmp_rx_word_t RX_IN,
   input logic RX_IN_VALID,
   output logic RX_IN_READY,
   output pmp_pkg::pmp_tx_word_t TX_OUT,
   output logic TX_OUT_VALID
);
   import pmp_pkg::*;

   // Link domain: pin synchronisers, reset and clock enable carried across too
   logic [SYNC_W-1:0] sync1;
   logic [SYNC_W-1:0] sync2;
   logic lrst_n, lce, s_en, s_er;
   logic [3:0] s_txd;
   logic strap_done, rmii, master;
   logic [2:0] thr;
   logic clk_tog, ph;
   // Core-domain gray pointers, only read here through two flops
   logic [PTR_W-1:0] rx_wgray, tx_rgray;

   always_ff @(posedge REF_CLOCK_INPUT_PIN)
   begin
      sync1 <= {NRST, CE, RMII_MODE, RMII_MASTER, FIFO_THRESH, TX_ER, TX_EN, TXD};
      sync2 <= sync1;
   end

   assign lrst_n = sync2[12];
   assign lce = sync2[11];
   assign s_er = sync2[5];
   assign s_en = sync2[4];
   assign s_txd = sync2[3:0];

   // Straps are caught once, after the link reset releases
   logic next_strap_done, next_rmii, next_master, next_clk_tog, next_mii_clk;
   logic [2:0] next_thr;
   logic mii_clk;

   always_comb
   begin
      next_strap_done = strap_done;
      next_rmii = rmii;
      next_master = master;
      next_thr = thr;
      next_clk_tog = clk_tog;
      if (lce)
      begin
         if (!strap_done)
         begin
            next_strap_done = 1'b1;
            next_rmii = sync2[10];
            next_master = sync2[9];
            next_thr = clamp_thr(sync2[8:6]);
         end
         // Slave mode transfers on every reference edge; others on half rate
         next_clk_tog = (rmii && !master) ? 1'b0 : ~clk_tog;
      end
      next_mii_clk = next_clk_tog && !next_rmii;
   end

   // Transfer edge: rising edge of the clock this end sees or drives
   assign ph = (rmii && !master) ? 1'b1 : !clk_tog;

   always_ff @(posedge REF_CLOCK_INPUT_PIN)
   begin
      if (!lrst_n)
      begin
         strap_done <= 1'b0;
         rmii <= 1'b0;
         master <= 1'b0;
         thr <= THR_RST;
         clk_tog <= 1'b0;
         mii_clk <= 1'b0;
      end
      else
      begin
         strap_done <= next_strap_done;
         rmii <= next_rmii;
         master <= next_master;
         thr <= next_thr;
         clk_tog <= next_clk_tog;
         mii_clk <= next_mii_clk;
      end
   end

   assign MII_TX_CLK = mii_clk;
   assign MII_RX_CLK = mii_clk;

   // Transmit capture into the link-to-core FIFO
   logic prev_en, half, next_prev_en, next_half, tx_push, tx_full;
   logic [1:0] lo, next_lo;
   logic [PTR_W-1:0] tx_wbin, next_tx_wbin, tx_wgray, tx_rg_s1, tx_rg_s2;
   pmp_tx_word_t tx_wdata;

   assign tx_full = tx_wgray == {~tx_rg_s2[3:2], tx_rg_s2[1:0]};

   always_comb
   begin
      next_prev_en = prev_en;
      next_half = half;
      next_lo = lo;
      tx_push = 1'b0;
      tx_wdata = TX_END;
      if (lce && ph && strap_done)
      begin
         next_prev_en = s_en;
         // Enable low with error high is reserved and handled as idle
         if (s_en)
         begin
            if (!rmii)
            begin
               tx_push = 1'b1;
               tx_wdata.en = 1'b1;
               tx_wdata.er = s_er;
               tx_wdata.nib = s_txd;
            end
            else
            begin
               next_half = !half;
               next_lo = s_txd[1:0];
               if (half)
               begin
                  tx_push = 1'b1;
                  tx_wdata.en = 1'b1;
                  tx_wdata.nib = {s_txd[1:0], lo};
               end
            end
         end
         else if (prev_en)
         begin
            tx_push = 1'b1;
            next_half = 1'b0;
         end
      end
      // A full FIFO drops the nibble; the core drains faster than the link fills
      if (tx_full)
      begin
         tx_push = 1'b0;
      end
      next_tx_wbin = tx_wbin + {3'h0, tx_push};
   end

   always_ff @(posedge REF_CLOCK_INPUT_PIN)
   begin
      if (!lrst_n)
      begin
         prev_en <= 1'b0;
         half <= 1'b0;
         lo <= 2'h0;
         tx_wbin <= PTR_RST;
         tx_wgray <= PTR_RST;
      end
      else
      begin
         prev_en <= next_prev_en;
         half <= next_half;
         lo <= next_lo;
         tx_wbin <= next_tx_wbin;
         tx_wgray <= bin2gray(next_tx_wbin);
      end
   end

   // Receive side: elastic FIFO drained onto the pins
   logic [PTR_W-1:0] rx_rbin, next_rx_rbin, rx_rgray, rx_wg_s1, rx_wg_s2, fill, need;
   logic running, next_running, rhalf, next_rhalf, cur_run, rx_pop;
   logic next_dv, next_er, next_crs;
   logic [3:0] next_rxd;
   logic [RXW_W-1:0] rx_rdata;
   pmp_rx_word_t rx_word;
   logic [1:0] dib;

   assign rx_word = pmp_rx_word_t'(rx_rdata);
   assign fill = gray2bin(rx_wg_s2) - rx_rbin;
   assign need = need_entries(rmii, thr);
   assign cur_run = running || (fill >= need);

   always_comb
   begin
      next_running = running;
      next_rhalf = rhalf;
      next_dv = RX_DV;
      next_er = RX_ER;
      next_rxd = RXD;
      rx_pop = 1'b0;
      dib = rhalf ? rx_word.nib[3:2] : rx_word.nib[1:0];
      if (lce && ph && strap_done)
      begin
         next_dv = 1'b0;
         next_er = 1'b0;
         next_rxd = IDLE_NIB;
         if (cur_run && fill != PTR_RST)
         begin
            next_dv = rx_word.dv;
            next_er = rx_word.dv ? rx_word.err : rx_word.fc;
            if (!rmii)
            begin
               rx_pop = 1'b1;
               if (rx_word.dv)
               begin
                  next_rxd = rx_word.nib;
               end
               else if (rx_word.fc)
               begin
                  next_rxd = FALSE_CARRIER_NIB;
               end
               next_running = rx_word.dv;
            end
            else
            begin
               // Idle dibits stay 00 even when error carries false carrier
               next_rxd = {2'h0, rx_word.dv ? dib : 2'h0};
               rx_pop = rhalf;
               next_rhalf = !rhalf;
               next_running = rx_word.dv || !rhalf;
            end
         end
         else
         begin
            // Underflow mid-frame ends the frame rather than stall the pins
            next_running = 1'b0;
            next_rhalf = 1'b0;
         end
      end
      // Next strap values, so the output clock toggles from the strap edge on
      if (lce && next_rmii)
      begin
         next_rxd[3] = next_master ? next_clk_tog : 1'b0;
      end
      next_crs = rmii ? next_dv : 1'b0;
      next_rx_rbin = rx_rbin + {3'h0, rx_pop};
   end

   always_ff @(posedge REF_CLOCK_INPUT_PIN)
   begin
      if (!lrst_n)
      begin
         rx_rbin <= PTR_RST;
         rx_rgray <= PTR_RST;
         running <= 1'b0;
         rhalf <= 1'b0;
         RXD <= IDLE_NIB;
         RX_DV <= 1'b0;
         RX_ER <= 1'b0;
         CRS_DV <= 1'b0;
         rx_wg_s1 <= PTR_RST;
         rx_wg_s2 <= PTR_RST;
         tx_rg_s1 <= PTR_RST;
         tx_rg_s2 <= PTR_RST;
      end
      else
      begin
         rx_rbin <= next_rx_rbin;
         rx_rgray <= bin2gray(next_rx_rbin);
         running <= next_running;
         rhalf <= next_rhalf;
         RXD <= next_rxd;
         RX_DV <= next_dv;
         RX_ER <= next_er;
         CRS_DV <= next_crs;
         if (lce)
         begin
            rx_wg_s1 <= rx_wgray;
            rx_wg_s2 <= rx_wg_s1;
            tx_rg_s1 <= tx_rgray;
            tx_rg_s2 <= tx_rg_s1;
         end
      end
   end

   // Core domain: receive words in, transmit words out
   logic [PTR_W-1:0] rx_wbin, next_rx_wbin, rx_rg_s1, rx_rg_s2;
   logic [PTR_W-1:0] tx_rbin, next_tx_rbin, tx_wg_s1, tx_wg_s2;
   logic rx_wr, tx_pop, tx_vld, next_ready;
   logic [TXW_W-1:0] tx_rdata;

   assign rx_wr = CE && RX_IN_VALID && RX_IN_READY;
   assign tx_pop = CE && (tx_rgray != tx_wg_s2);

   always_comb
   begin
      next_rx_wbin = rx_wbin + {3'h0, rx_wr};
      next_ready = (next_rx_wbin - gray2bin(rx_rg_s2)) != FIFO_DEPTH;
      next_tx_rbin = tx_rbin + {3'h0, tx_pop};
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (!NRST)
      begin
         rx_wbin <= PTR_RST;
         rx_wgray <= PTR_RST;
         rx_rg_s1 <= PTR_RST;
         rx_rg_s2 <= PTR_RST;
         RX_IN_READY <= 1'b0;
         tx_rbin <= PTR_RST;
         tx_rgray <= PTR_RST;
         tx_wg_s1 <= PTR_RST;
         tx_wg_s2 <= PTR_RST;
         tx_vld <= 1'b0;
         TX_OUT <= TX_END;
         TX_OUT_VALID <= 1'b0;
      end
      else if (CE)
      begin
         rx_wbin <= next_rx_wbin;
         rx_wgray <= bin2gray(next_rx_wbin);
         rx_rg_s1 <= rx_rgray;
         rx_rg_s2 <= rx_rg_s1;
         RX_IN_READY <= next_ready;
         tx_rbin <= next_tx_rbin;
         tx_rgray <= bin2gray(next_tx_rbin);
         tx_wg_s1 <= tx_wgray;
         tx_wg_s2 <= tx_wg_s1;
         tx_vld <= tx_pop;
         TX_OUT <= tx_vld ? pmp_tx_word_t'(tx_rdata) : TX_END;
         TX_OUT_VALID <= tx_vld;
      end
   end

   pmp_mem #(.W(RXW_W), .AW(FIFO_AW)) rx_mem (
      .wclk(CORE_CLK),
      .we(rx_wr),
      .waddr(rx_wbin[FIFO_AW-1:0]),
      .wdata(RX_IN),
      .rclk(REF_CLOCK_INPUT_PIN),
      .re(lce),
      .raddr(next_rx_rbin[FIFO_AW-1:0]),
      .rdata(rx_rdata)
   );

   pmp_mem #(.W(TXW_W), .AW(FIFO_AW)) tx_mem (
      .wclk(REF_CLOCK_INPUT_PIN),
      .we(tx_push),
      .waddr(tx_wbin[FIFO_AW-1:0]),
      .wdata(tx_wdata),
      .rclk(CORE_CLK),
      .re(CE),
      .raddr(tx_rbin[FIFO_AW-1:0]),
      .rdata(tx_rdata)
   );

   sequence s_rx_word;
      lce && ph && strap_done && cur_run && (fill != PTR_RST);
   endsequence

   sequence s_tx_pop;
      tx_pop ##1 CE;
   endsequence

   property p_mii_clk;
      @(posedge REF_CLOCK_INPUT_PIN) disable iff (!lrst_n)
      (lce && strap_done && !rmii) |=> (MII_TX_CLK != $past(MII_TX_CLK));
   endproperty
   mii_clock_toggle_a: assert property (p_mii_clk) else $error("MII clock stalled");

   property p_false_carrier;
      @(posedge REF_CLOCK_INPUT_PIN) disable iff (!lrst_n)
      (s_rx_word and (!rmii && !rx_word.dv && rx_word.fc))
      |=> (RXD == FALSE_CARRIER_NIB && RX_ER && !RX_DV);
   endproperty
   false_carrier_a: assert property (p_false_carrier) else $error("Bad false carrier");

   property p_rx_error;
      @(posedge REF_CLOCK_INPUT_PIN) disable iff (!lrst_n)
      (s_rx_word and rx_word.dv) |=> (RX_DV && RX_ER == $past(rx_word.err));
   endproperty
   rx_error_flag_a: assert property (p_rx_error) else $error("Receive error mismatch");

   property p_rmii_idle;
      @(posedge REF_CLOCK_INPUT_PIN) disable iff (!lrst_n)
      (strap_done && rmii && !CRS_DV) |-> (RXD[1:0] == 2'h0);
   endproperty
   rmii_idle_dibit_a: assert property (p_rmii_idle) else $error("RMII idle dibit");

   property p_rx_dv;
      @(posedge REF_CLOCK_INPUT_PIN) disable iff (!lrst_n)
      (strap_done && rmii) |=> (RX_DV == CRS_DV);
   endproperty
   rmii_rx_valid_a: assert property (p_rx_dv) else $error("RX valid differs");

   property p_master_clk;
      @(posedge REF_CLOCK_INPUT_PIN) disable iff (!lrst_n)
      (lce && strap_done && rmii && master) |=> (RXD[3] != $past(RXD[3]));
   endproperty
   master_clock_out_a: assert property (p_master_clk) else $error("Master clock stalled");

   property p_threshold;
      @(posedge REF_CLOCK_INPUT_PIN) disable iff (!lrst_n)
      (lce && ph && strap_done && !running && fill < need) |=> (!RX_DV && !running);
   endproperty
   fifo_start_hold_a: assert property (p_threshold) else $error("Started early");

   property p_rmii_pair;
      @(posedge REF_CLOCK_INPUT_PIN) disable iff (!lrst_n)
      (lce && ph && strap_done && rmii && s_en && half && !tx_full)
      |-> (tx_push && tx_wdata.nib == {s_txd[1:0], lo});
   endproperty
   rmii_dibit_pair_a: assert property (p_rmii_pair) else $error("Dibit pairing");

   property p_tx_deliver;
      @(posedge CORE_CLK) disable iff (!NRST)
      s_tx_pop |=> TX_OUT_VALID;
   endproperty
   tx_word_deliver_a: assert property (p_tx_deliver) else $error("TX word lost");
endmodule : pmp_mii_rmii_port

// [pmp_mii_rmii_port_tb.sv]
module pmp_mii_rmii_port_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import pmp_pkg::*;
   logic core_clk = 1'b0;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic rmii_mode = 1'b0;
   logic rmii_master = 1'b0;
   logic [2:0] fifo_thresh = 3'h2;
   logic [3:0] txd;
   logic tx_en;
   logic tx_er;
   logic [3:0] rxd;
   logic rx_dv;
   logic rx_er;
   logic mii_tx_clk;
   logic mii_rx_clk;
   logic crs_dv;
   logic xfer_clk;
   int rxc_cnt = 0;
   int crs_bad = 0;
   pmp_rx_word_t rx_in = '0;
   logic rx_in_valid = 1'b0;
   logic rx_in_ready;
   pmp_tx_word_t tx_out;
   logic tx_out_valid;
   logic [5:0] txo_q[$];
   int clk_cnt = 0;
   int num_errors = 0;
   int num_checks = 0;

   always #5 core_clk = ~core_clk;
   always #7.5 ref_clk = ~ref_clk;
   // Master mode: the MAC runs from the clock the port puts on bit 3
   assign xfer_clk = rmii_mode ? (rmii_master ? rxd[3] : ref_clk) : mii_tx_clk;
   always @(posedge xfer_clk) clk_cnt++;
   always @(posedge mii_rx_clk) rxc_cnt++;
   // Carrier/valid must track receive valid in RMII and stay low in MII
   always @(negedge xfer_clk)
   begin
      if (crs_dv !== (rmii_mode ? rx_dv : 1'b0))
      begin
         crs_bad++;
      end
   end
   always @(posedge core_clk)
   begin
      if (tx_out_valid === 1'b1 && tx_out.en === 1'b1)
      begin
         txo_q.push_back(tx_out);
      end
   end

   pmp_mii_rmii_port uut (
      .CORE_CLK(core_clk), .NRST(nrst), .CE(1'b1), .REF_CLOCK_INPUT_PIN(ref_clk),
      .RMII_MODE(rmii_mode), .RMII_MASTER(rmii_master), .FIFO_THRESH(fifo_thresh),
      .TXD(txd), .TX_EN(tx_en), .TX_ER(tx_er), .RXD(rxd), .RX_DV(rx_dv), .RX_ER(rx_er),
      .CRS_DV(crs_dv), .MII_TX_CLK(mii_tx_clk), .MII_RX_CLK(mii_rx_clk), .RX_IN(rx_in),
      .RX_IN_VALID(rx_in_valid), .RX_IN_READY(rx_in_ready), .TX_OUT(tx_out),
      .TX_OUT_VALID(tx_out_valid)
   );

   pmp_mac_model mac (
      .xfer_clk(xfer_clk), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er),
      .txd(txd), .tx_en(tx_en), .tx_er(tx_er)
   );

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check

   task automatic close_out;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : close_out

   // Straps are caught once after reset, so every mode change needs a reset
   task automatic set_mode(input logic r, input logic ms, input logic [2:0] thr);
      nrst = 1'b0;
      rmii_mode = r;
      rmii_master = ms;
      fifo_thresh = thr;
      repeat (10) @(posedge core_clk);
      #1 nrst = 1'b1;
      repeat (20) @(posedge core_clk);
      #1;
   endtask : set_mode

   task automatic push(input pmp_rx_word_t w);
      int n;
      n = 0;
      rx_in = w;
      rx_in_valid = 1'b1;
      @(negedge core_clk);
      while (rx_in_ready !== 1'b1 && n < 50)
      begin
         @(negedge core_clk);
         n++;
      end
      @(posedge core_clk);
      #1;
   endtask : push

   task automatic do_rx;
      pmp_rx_word_t w[6];
      logic [5:0] e[$];
      logic [5:0] m;
      int n;
      w = '{7'h45, 7'h4A, 7'h63, 7'h00, 7'h3E, 7'h00};
      m = rmii_mode ? 6'h33 : 6'h3F;
      for (int i = 0; i < 5; i++)
      begin
         if (w[i].dv && rmii_mode)
         begin
            e.push_back({1'b1, w[i].err, 2'b00, w[i].nib[1:0]});
            e.push_back({1'b1, w[i].err, 2'b00, w[i].nib[3:2]});
         end
         else if (w[i].dv)
            e.push_back({1'b1, w[i].err, w[i].nib});
         else if (w[i].fc && rmii_mode)
         begin
            e.push_back(6'h10);
            e.push_back(6'h10);
         end
         else if (w[i].fc)
            e.push_back({2'b01, FALSE_CARRIER_NIB});
      end
      mac.rx_q.delete();
      crs_bad = 0;
      for (int i = 0; i < 6; i++) push(w[i]);
      rx_in_valid = 1'b0;
      n = 0;
      while (mac.rx_q.size() < e.size() && n < 300)
      begin
         @(posedge core_clk);
         n++;
      end
      repeat (30) @(posedge core_clk);
      #1;
      check(8'(mac.rx_q.size()), 8'(e.size()));
      for (int i = 0; i < e.size() && i < mac.rx_q.size(); i++)
         check({2'b00, mac.rx_q[i] & m}, {2'b00, e[i]});
      check(8'(crs_bad), 8'h00);
   endtask : do_rx

   task automatic do_tx;
      logic [5:0] e[$];
      int n;
      txo_q.delete();
      if (rmii_mode)
      begin
         mac.tx_q = '{6'h21, 6'h22, 6'h23, 6'h20, 6'h00, 6'h01, 6'h00};
         e = '{6'h29, 6'h23};
      end
      else
      begin
         mac.tx_q = '{6'h27, 6'h3C, 6'h29, 6'h00, 6'h15, 6'h00};
         e = '{6'h27, 6'h3C, 6'h29};
      end
      n = 0;
      while (txo_q.size() < e.size() && n < 300)
      begin
         @(posedge core_clk);
         n++;
      end
      repeat (30) @(posedge core_clk);
      #1;
      check(8'(txo_q.size()), 8'(e.size()));
      for (int i = 0; i < e.size() && i < txo_q.size(); i++)
         check({2'b00, txo_q[i]}, {2'b00, e[i]});
   endtask : do_tx

   // Output clock is half the link clock: 40 link periods give 20 rises
   task automatic do_clk;
      clk_cnt = 0;
      rxc_cnt = 0;
      #600;
      check({7'h00, clk_cnt >= 19 && clk_cnt <= 21}, 8'h01);
      if (rmii_mode)
         check(8'(rxc_cnt), 8'h00);
      else
         check({7'h00, rxc_cnt >= 19 && rxc_cnt <= 21}, 8'h01);
   endtask : do_clk

   initial
   begin
      #300000;
      num_errors++;
      close_out();
   end

   initial
   begin
      set_mode(1'b0, 1'b0, 3'h2);
      do_rx();
      do_tx();
      do_clk();
      set_mode(1'b1, 1'b0, 3'h5);
      do_rx();
      do_tx();
      set_mode(1'b1, 1'b1, 3'h2);
      do_rx();
      do_tx();
      do_clk();
      close_out();
   end
endmodule : pmp_mii_rmii_port_tb

// [pmp_pkg.sv]
package pmp_pkg;

   localparam int FIFO_AW = 3;
   localparam int PTR_W = 4;
   localparam logic [PTR_W-1:0] FIFO_DEPTH = 4'h8;
   localparam logic [PTR_W-1:0] PTR_RST = 4'h0;
   localparam logic [PTR_W-1:0] PTR_ONE = 4'h1;
   localparam logic [3:0] FALSE_CARRIER_NIB = 4'hE;
   localparam logic [3:0] IDLE_NIB = 4'h0;
   localparam logic [2:0] THR_MIN = 3'h2;
   localparam logic [2:0] THR_MAX = 3'h5;
   localparam logic [2:0] THR_RST = 3'h2;
   localparam logic [3:0] THR_ROUND = 4'h3;
   localparam int SYNC_W = 13;
   localparam logic [SYNC_W-1:0] SYNC_RST = 13'h0;

   typedef struct packed {
      logic dv;
      logic err;
      logic fc;
      logic [3:0] nib;
   } pmp_rx_word_t;

   typedef struct packed {
      logic en;
      logic er;
      logic [3:0] nib;
   } pmp_tx_word_t;

   localparam int RXW_W = $bits(pmp_rx_word_t);
   localparam int TXW_W = $bits(pmp_tx_word_t);
   localparam pmp_rx_word_t RX_IDLE = '0;
   localparam pmp_tx_word_t TX_END = '0;

   function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
      return b ^ (b >> 1);
   endfunction : bin2gray

   function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
      logic [PTR_W-1:0] b;
      b = '0;
      for (int i = PTR_W - 1; i >= 0; i--)
      begin
         b[i] = (i == PTR_W - 1) ? g[i] : (b[i+1] ^ g[i]);
      end
      return b;
   endfunction : gray2bin

   // Entries of four bits needed before reception starts
   function automatic logic [PTR_W-1:0] need_entries(input logic rmii, input logic [2:0] thr);
      if (!rmii)
      begin
         return PTR_ONE;
      end
      return ({1'b0, thr} + THR_ROUND) >> 2;
   endfunction : need_entries

   function automatic logic [2:0] clamp_thr(input logic [2:0] thr);
      if (thr < THR_MIN)
      begin
         return THR_MIN;
      end
      if (thr > THR_MAX)
      begin
         return THR_MAX;
      end
      return thr;
   endfunction : clamp_thr

endpackage : pmp_pkg
